// ---- smd_pkg.sv ----
// constants, field layout and carrier types of the supply monitor and diagnostics block
package smd_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned ADDR_W          = 7;

    // register map
    localparam logic [6:0] ADDR_FUNC_CTRL   = 7'h00;
    localparam logic [6:0] ADDR_GATE_CODE   = 7'h15;
    localparam logic [6:0] ADDR_OV_THR      = 7'h1a;
    localparam logic [6:0] ADDR_UV_THR      = 7'h1b;
    localparam logic [6:0] ADDR_LIMP_CTRL   = 7'h3c;
    localparam logic [6:0] ADDR_VBAT_READ   = 7'h44;
    localparam logic [6:0] ADDR_TEMP_READ   = 7'h46;
    localparam logic [6:0] ADDR_DIAG        = 7'h4c;
    localparam logic [6:0] ADDR_FALLBACK    = 7'h54;

    // field positions
    localparam int unsigned FC_CFG_DONE     = 0;
    localparam int unsigned FC_OUT1_EN      = 1;
    localparam int unsigned FC_OUT2_EN      = 2;
    localparam int unsigned FC_MEAS_EN      = 6;
    localparam int unsigned LC_TIMER_LSB    = 1;
    localparam int unsigned LC_EXIT_LSB     = 4;
    localparam int unsigned FB_ACTIVE_BIT   = 3;

    // reset values
    localparam logic [7:0] FUNC_CTRL_RST    = 8'h00;
    localparam logic [7:0] GATE_CODE_RST    = 8'h80;
    localparam logic [7:0] OV_THR_RST       = 8'hff;
    localparam logic [7:0] UV_THR_RST       = 8'h00;
    localparam logic [2:0] LH_SEL_RST       = 3'h0;

    // gate-supply code limits
    localparam logic [7:0] GATE_CODE_MIN_STD = 8'h80;
    localparam logic [7:0] GATE_CODE_MIN_EXT = 8'h5d;
    localparam logic [7:0] GATE_CODE_MAX     = 8'hb7;

    // exit field patterns
    localparam logic [2:0] EXIT_REFRESH     = 3'h7;
    localparam logic [2:0] EXIT_STEP1       = 3'h1;
    localparam logic [2:0] EXIT_STEP2       = 3'h2;
    localparam logic [2:0] EXIT_STEP3       = 3'h4;

    // timing
    localparam int unsigned LH_SEL_N        = 8;
    localparam int unsigned LH_CNT_W        = 28;
    localparam int unsigned LH_TIME_NS [LH_SEL_N] = '{
        5409600, 10819200, 21639600, 43279200,
        86558400, 173116800, 346233600, 692479200};
    localparam int unsigned LH_CYC [LH_SEL_N] = '{
        LH_TIME_NS[0] / CLK_PERIOD_NS, LH_TIME_NS[1] / CLK_PERIOD_NS,
        LH_TIME_NS[2] / CLK_PERIOD_NS, LH_TIME_NS[3] / CLK_PERIOD_NS,
        LH_TIME_NS[4] / CLK_PERIOD_NS, LH_TIME_NS[5] / CLK_PERIOD_NS,
        LH_TIME_NS[6] / CLK_PERIOD_NS, LH_TIME_NS[7] / CLK_PERIOD_NS};
    localparam int unsigned STARTUP_TIME_NS = 1000;
    localparam int unsigned FILTER_TIME_NS  = 500;
    localparam int unsigned STARTUP_CYC_DEF =
        (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FILTER_CYC_DEF  =
        (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_START = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_FAIL  = 4'b1000
    } smd_state_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] data;
    } smd_req_s;

    typedef struct packed {
        logic [7:0] vbatCode;
        logic [7:0] tempCode;
        logic       tempOver;
        logic       gateInWindow;
        logic       out1InWindow;
        logic       out2InWindow;
    } smd_analog_s;

    typedef struct packed {
        logic       rangeExt;
        logic       restartTemp;
        logic       restartUv;
        logic       restartOv;
        logic       limpEnable;
        logic       useMode;
        logic [7:0] limpFuncCtrl;
        logic [7:0] limpGateCode;
    } smd_nvm_s;

    function automatic logic gateCodeAllowed(input logic [7:0] code, input logic ext);
        logic [7:0] lo;
        lo = ext ? GATE_CODE_MIN_EXT : GATE_CODE_MIN_STD;
        return (code >= lo) && (code <= GATE_CODE_MAX);
    endfunction

endpackage

// ---- smd_level_filter.sv ----
`timescale 1ns/100ps
// level filter that follows its input only after it has held longer than the hold time
module smd_level_filter #(
    parameter int unsigned HOLD_CYC = 4,
    parameter int unsigned CNT_W    = $clog2(HOLD_CYC + 1)
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // level in, filtered level out
    input  wire logic level,
    output logic      filtered
);

    if (HOLD_CYC < 1 || CNT_W < $clog2(HOLD_CYC + 1)) begin : gBadHold
        $error("hold count must be at least one and fit the counter");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             filt_q;
    logic             filt_d;

    // a glitch shorter than the hold time restarts the count
    always_comb begin
        filt_d = filt_q;
        cnt_d  = '0;
        if (level != filt_q) begin
            if (cnt_q == CNT_W'(HOLD_CYC)) begin
                filt_d = level;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q  <= '0;
            filt_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            filt_q <= filt_d;
        end
    end

    assign filtered = filt_q;

endmodule

// ---- smd_supply_monitor.sv ----
`timescale 1ns/100ps
// supervision, diagnostics, fail silent and fallback control of the boost controller
module smd_supply_monitor
    import smd_pkg::*;
#(
    parameter int unsigned STARTUP_CYC        = STARTUP_CYC_DEF,
    parameter int unsigned FILTER_CYC         = FILTER_CYC_DEF,
    parameter int unsigned LH_CYC_P [LH_SEL_N] = LH_CYC
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // deframed serial register access
    input  wire smd_req_s    regReq,
    output logic [7:0]       regRdData,
    output logic             regRdValid,
    // analog monitor codes and comparators
    input  wire smd_analog_s anaIn,
    // nvm-held configuration
    input  wire smd_nvm_s    nvmCfg,
    // power stage control
    output logic             gateSupplyOn,
    output logic             switchEn1,
    output logic             switchEn2,
    output logic             failSilent,
    output logic             fallbackActive
);

    localparam int unsigned ST_CNT_W = $clog2(STARTUP_CYC + 1);

    if (STARTUP_CYC < 1 || FILTER_CYC < 1) begin : gBadTime
        $error("startup and filter counts must be at least one");
    end
    for (genvar i = 0; i < LH_SEL_N; i++) begin : gLhChk
        if (LH_CYC_P[i] < 1 || LH_CYC_P[i] >= (1 << LH_CNT_W)) begin : gBadLh
            $error("watch timeout count out of range");
        end
    end

    // pin synchroniser: analog flags and codes arrive from another domain
    smd_analog_s anaMeta_q;
    smd_analog_s ana_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            anaMeta_q <= '0;
            ana_q     <= '0;
        end else begin
            anaMeta_q <= anaIn;
            ana_q     <= anaMeta_q;
        end
    end

    // register state
    logic [7:0]          funcCtrl_q,  funcCtrl_d;
    logic [7:0]          gateCode_q,  gateCode_d;
    logic [7:0]          ovThr_q,     ovThr_d;
    logic [7:0]          uvThr_q,     uvThr_d;
    logic [2:0]          lhSel_q,     lhSel_d;
    logic [7:0]          vbatRd_q,    vbatRd_d;
    logic [7:0]          tempRd_q,    tempRd_d;
    logic [7:0]          rdData_q,    rdData_d;
    logic                rdValid_q,   rdValid_d;
    logic                tjFlag_q,    tjFlag_d;
    logic                uvFlag_q,    uvFlag_d;
    logic                ovFlag_q,    ovFlag_d;
    logic                serFlag_q,   serFlag_d;
    logic                gerrFlag_q,  gerrFlag_d;
    logic                fallback_q,  fallback_d;
    logic [1:0]          exitStep_q,  exitStep_d;
    logic [LH_CNT_W-1:0] lhCnt_q,     lhCnt_d;

    // supervision state
    smd_state_e          state_q,     state_d;
    logic [ST_CNT_W-1:0] stCnt_q,     stCnt_d;
    logic [3:0]          cause_q,     cause_d;
    logic                gateGood_q,  gateGood_d;
    logic                supplyOn_q,  supplyOn_d;
    logic                sw1_q,       sw1_d;
    logic                sw2_q,       sw2_d;
    logic                fail_q,      fail_d;

    // decoded conditions
    logic       opMode;
    logic       outReq;
    logic       measOn;
    logic       faultTj;
    logic       faultUv;
    logic       faultOv;
    logic       wrOk;
    logic       rdOk;
    logic       wrDo;
    logic       cmdErr;
    logic       diagWr;
    logic       lcWr;
    logic [2:0] exitPat;
    logic       gerrSet;
    logic       out1Ok;
    logic       out2Ok;

    assign opMode  = funcCtrl_q[FC_CFG_DONE];
    assign outReq  = opMode && !nvmCfg.useMode
                     && (funcCtrl_q[FC_OUT1_EN] || funcCtrl_q[FC_OUT2_EN]);
    assign measOn  = outReq || funcCtrl_q[FC_MEAS_EN];
    assign faultTj = ana_q.tempOver;
    assign faultUv = measOn && (ana_q.vbatCode < uvThr_q);
    assign faultOv = measOn && (ana_q.vbatCode > ovThr_q);
    assign exitPat = regReq.data[LC_EXIT_LSB +: 3];

    smd_level_filter #(
        .HOLD_CYC (FILTER_CYC)
    ) uOut1Filt (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .level    (ana_q.out1InWindow),
        .filtered (out1Ok)
    );

    smd_level_filter #(
        .HOLD_CYC (FILTER_CYC)
    ) uOut2Filt (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .level    (ana_q.out2InWindow),
        .filtered (out2Ok)
    );

    // access check: locked, read-only, out-of-range writes and fallback writes other than to limp control are refused
    always_comb begin
        wrOk = 1'b0;
        rdOk = 1'b1;
        unique case (regReq.addr)
            ADDR_FUNC_CTRL, ADDR_DIAG, ADDR_LIMP_CTRL: begin
                wrOk = 1'b1;
            end
            ADDR_GATE_CODE: begin
                wrOk = !opMode && gateCodeAllowed(regReq.data, nvmCfg.rangeExt);
            end
            ADDR_OV_THR, ADDR_UV_THR: begin
                wrOk = !opMode;
            end
            ADDR_VBAT_READ, ADDR_TEMP_READ, ADDR_FALLBACK: begin
                wrOk = 1'b0;
            end
            default: begin
                rdOk = 1'b0;
            end
        endcase
        if (fallback_q && regReq.addr != ADDR_LIMP_CTRL) begin
            wrOk = 1'b0;
        end
        wrDo   = regReq.wr && wrOk;
        cmdErr = (regReq.wr && !wrOk) || (regReq.rd && !rdOk);
        diagWr = wrDo && regReq.addr == ADDR_DIAG;
        lcWr   = wrDo && regReq.addr == ADDR_LIMP_CTRL;
    end

    // read port: data one cycle after the strobe
    always_comb begin
        rdValid_d = regReq.rd;
        rdData_d  = 8'h00;
        if (regReq.rd) begin
            unique case (regReq.addr)
                ADDR_FUNC_CTRL: rdData_d = funcCtrl_q;
                ADDR_GATE_CODE: rdData_d = gateCode_q;
                ADDR_OV_THR:    rdData_d = ovThr_q;
                ADDR_UV_THR:    rdData_d = uvThr_q;
                ADDR_LIMP_CTRL: rdData_d = 8'({lhSel_q, 1'b0});
                ADDR_VBAT_READ: rdData_d = vbatRd_q;
                ADDR_TEMP_READ: rdData_d = tempRd_q;
                ADDR_DIAG:      rdData_d = {out1Ok, out2Ok, gateGood_q, tjFlag_q, uvFlag_q,
                                            ovFlag_q, serFlag_q, gerrFlag_q};
                ADDR_FALLBACK:  rdData_d = 8'(fallback_q) << FB_ACTIVE_BIT;
                default:        rdData_d = 8'h00;
            endcase
        end
    end

    // configuration registers, fallback watch and exit sequence
    always_comb begin
        funcCtrl_d = funcCtrl_q;
        gateCode_d = gateCode_q;
        ovThr_d    = ovThr_q;
        uvThr_d    = uvThr_q;
        lhSel_d    = lhSel_q;
        fallback_d = fallback_q;
        exitStep_d = exitStep_q;
        lhCnt_d    = lhCnt_q;
        if (wrDo) begin
            unique case (regReq.addr)
                ADDR_FUNC_CTRL: funcCtrl_d = regReq.data;
                ADDR_GATE_CODE: gateCode_d = regReq.data;
                ADDR_OV_THR:    ovThr_d    = regReq.data;
                ADDR_UV_THR:    uvThr_d    = regReq.data;
                ADDR_LIMP_CTRL: lhSel_d    = regReq.data[LC_TIMER_LSB +: 3];
                default:        lhSel_d    = lhSel_q;
            endcase
        end
        if (fallback_q) begin
            lhCnt_d = '0;
            // a wrong pattern restarts the sequence, a refresh leaves it where it is
            if (lcWr && exitPat != EXIT_REFRESH) begin
                if (exitStep_q == 2'd0 && exitPat == EXIT_STEP1) begin
                    exitStep_d = 2'd1;
                end else if (exitStep_q == 2'd1 && exitPat == EXIT_STEP2) begin
                    exitStep_d = 2'd2;
                end else if (exitStep_q == 2'd2 && exitPat == EXIT_STEP3) begin
                    exitStep_d = 2'd0;
                    fallback_d = 1'b0;
                end else begin
                    exitStep_d = 2'd0;
                end
            end
        end else if (nvmCfg.limpEnable && opMode) begin
            if (lcWr && exitPat == EXIT_REFRESH) begin
                lhCnt_d = '0;
            end else if (lhCnt_q >= LH_CNT_W'(LH_CYC_P[lhSel_q] - 1)) begin
                lhCnt_d    = '0;
                fallback_d = 1'b1;
                exitStep_d = 2'd0;
                funcCtrl_d = nvmCfg.limpFuncCtrl;
                gateCode_d = nvmCfg.limpGateCode;
            end else begin
                lhCnt_d = lhCnt_q + 1'b1;
            end
        end else begin
            lhCnt_d = '0;
        end
    end

    // supervision: startup, run, fail silent and auto restart
    always_comb begin
        state_d = state_q;
        stCnt_d = '0;
        cause_d = cause_q;
        gerrSet = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (outReq) begin
                    state_d = ST_START;
                end
            end
            ST_START: begin
                stCnt_d = stCnt_q + 1'b1;
                if (!outReq) begin
                    state_d = ST_IDLE;
                end else if (stCnt_q == ST_CNT_W'(STARTUP_CYC - 1)) begin
                    if (ana_q.gateInWindow) begin
                        state_d = ST_RUN;
                    end else begin
                        gerrSet = 1'b1;
                        cause_d = 4'b0001;
                        state_d = ST_FAIL;
                    end
                end
            end
            ST_RUN: begin
                if (!outReq) begin
                    state_d = ST_IDLE;
                end else if (!ana_q.gateInWindow) begin
                    cause_d = 4'b0001;
                    state_d = ST_FAIL;
                end
            end
            ST_FAIL: begin
                // a gate supply fault with no Tj, UV or OV fault in the same cycle never restarts: only an enable cycle recovers
                if ((!cause_q[3] || nvmCfg.restartTemp) && (!cause_q[2] || nvmCfg.restartUv)
                    && (!cause_q[1] || nvmCfg.restartOv) && !cause_q[0]
                    && !faultTj && !faultUv && !faultOv) begin
                    cause_d = 4'b0000;
                    state_d = ST_IDLE;
                end
            end
        endcase
        if (state_q != ST_IDLE && state_q != ST_FAIL && (faultTj || faultUv || faultOv)) begin
            cause_d = {faultTj, faultUv, faultOv, 1'b0};
            state_d = ST_FAIL;
        end
        gateGood_d = (state_d == ST_RUN);
        supplyOn_d = (state_d == ST_START) || (state_d == ST_RUN);
        sw1_d      = gateGood_d && funcCtrl_d[FC_OUT1_EN];
        sw2_d      = gateGood_d && funcCtrl_d[FC_OUT2_EN];
        fail_d     = (state_d == ST_FAIL);
    end

    // diagnostic flags: a new event wins over a clearing write in the same cycle
    always_comb begin
        tjFlag_d   = faultTj || (tjFlag_q && !diagWr);
        uvFlag_d   = faultUv || (uvFlag_q && !diagWr);
        ovFlag_d   = faultOv || (ovFlag_q && !diagWr);
        serFlag_d  = cmdErr || (serFlag_q && !diagWr);
        gerrFlag_d = gerrSet || (gerrFlag_q && !diagWr);
        vbatRd_d   = measOn ? ana_q.vbatCode : 8'h00;
        tempRd_d   = ana_q.tempCode;
    end

    // off mode is the enable-pin reset, which also clears every flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            funcCtrl_q <= FUNC_CTRL_RST;
            gateCode_q <= GATE_CODE_RST;
            ovThr_q    <= OV_THR_RST;
            uvThr_q    <= UV_THR_RST;
            lhSel_q    <= LH_SEL_RST;
            vbatRd_q   <= 8'h00;
            tempRd_q   <= 8'h00;
            rdData_q   <= 8'h00;
            rdValid_q  <= 1'b0;
            tjFlag_q   <= 1'b0;
            uvFlag_q   <= 1'b0;
            ovFlag_q   <= 1'b0;
            serFlag_q  <= 1'b0;
            gerrFlag_q <= 1'b0;
            fallback_q <= 1'b0;
            exitStep_q <= 2'd0;
            lhCnt_q    <= '0;
        end else begin
            funcCtrl_q <= funcCtrl_d;
            gateCode_q <= gateCode_d;
            ovThr_q    <= ovThr_d;
            uvThr_q    <= uvThr_d;
            lhSel_q    <= lhSel_d;
            vbatRd_q   <= vbatRd_d;
            tempRd_q   <= tempRd_d;
            rdData_q   <= rdData_d;
            rdValid_q  <= rdValid_d;
            tjFlag_q   <= tjFlag_d;
            uvFlag_q   <= uvFlag_d;
            ovFlag_q   <= ovFlag_d;
            serFlag_q  <= serFlag_d;
            gerrFlag_q <= gerrFlag_d;
            fallback_q <= fallback_d;
            exitStep_q <= exitStep_d;
            lhCnt_q    <= lhCnt_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            stCnt_q    <= '0;
            cause_q    <= 4'b0000;
            gateGood_q <= 1'b0;
            supplyOn_q <= 1'b0;
            sw1_q      <= 1'b0;
            sw2_q      <= 1'b0;
            fail_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            stCnt_q    <= stCnt_d;
            cause_q    <= cause_d;
            gateGood_q <= gateGood_d;
            supplyOn_q <= supplyOn_d;
            sw1_q      <= sw1_d;
            sw2_q      <= sw2_d;
            fail_q     <= fail_d;
        end
    end

    assign regRdData      = rdData_q;
    assign regRdValid     = rdValid_q;
    assign gateSupplyOn   = supplyOn_q;
    assign switchEn1      = sw1_q;
    assign switchEn2      = sw2_q;
    assign failSilent     = fail_q;
    assign fallbackActive = fallback_q;

endmodule

// ---- smd_checker.sv ----
// assertion checker watching the supply monitor ports
`timescale 1ns/100ps
module smd_checker
    import smd_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // register port
    input wire smd_req_s    regReq,
    input wire logic [7:0]  regRdData,
    input wire logic        regRdValid,
    // analog and nvm
    input wire smd_analog_s anaIn,
    input wire smd_nvm_s    nvmCfg,
    // power stage
    input wire logic        gateSupplyOn,
    input wire logic        switchEn1,
    input wire logic        switchEn2,
    input wire logic        failSilent,
    input wire logic        fallbackActive
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // short startup holds here, sim uses four cycles
    sequence quietStart;
        (!switchEn1 && !switchEn2)[*4];
    endsequence
    sequence noRestart;
        !nvmCfg.restartTemp && !nvmCfg.restartUv && !nvmCfg.restartOv;
    endsequence
    fail_off_a: assert property (failSilent |-> !switchEn1 && !switchEn2)
        else $error("switching while fail silent");
    start_wait_a: assert property ($rose(gateSupplyOn) |-> quietStart)
        else $error("switching before startup end");
    switch_good_a: assert property (switchEn1 || switchEn2 |-> gateSupplyOn)
        else $error("switching without gate supply");
    fail_hold_a: assert property (failSilent ##0 noRestart |=> failSilent)
        else $error("fail silent left without restart");
    use_mode_a: assert property (nvmCfg.useMode && !gateSupplyOn |=> !gateSupplyOn)
        else $error("output started in nvm use mode");
    fb_hold_a: assert property (fallbackActive && !(regReq.wr
        && regReq.addr == ADDR_LIMP_CTRL) |=> fallbackActive)
        else $error("fallback left without exit write");
    fb_cause_a: assert property ($rose(fallbackActive) |-> $past(nvmCfg.limpEnable))
        else $error("fallback without watch enabled");
    rd_answer_a: assert property (regReq.rd |=> regRdValid)
        else $error("read not answered");
    rd_idle_a: assert property (!regReq.rd |=> !regRdValid && regRdData == 8'h00)
        else $error("read data without read");
endmodule
bind smd_supply_monitor smd_checker chk (.sys_clk, .rst, .regReq, .regRdData,
    .regRdValid, .anaIn, .nvmCfg, .gateSupplyOn, .switchEn1, .switchEn2,
    .failSilent, .fallbackActive);

// ---- smd_host_model.sv ----
// host model issuing single-byte register accesses
`timescale 1ns/100ps
module smd_host_model
    import smd_pkg::*;
(
    // clock and read data
    input  wire logic       sys_clk,
    input  wire logic [7:0] regRdData,
    // request
    output smd_req_s        regReq
);
    initial regReq = '0;
    // idle bus shows inverted values so stale data never looks valid
    task automatic regWrite(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge sys_clk);
        regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask
    task automatic regRead(input logic [6:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge sys_clk);
        regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hff};
        @(negedge sys_clk);
        d = regRdData;
    endtask
endmodule

// ---- tb.sv ----
// self-checking bench for the supply monitor
`timescale 1ns/100ps
module tb;
    import smd_pkg::*;
    logic        sys_clk, rst, gOn, sw1, sw2, fsil, fbAct, rdv;
    logic [7:0]  rdData, v;
    smd_req_s    req;
    smd_analog_s ana;
    smd_nvm_s    nvm;
    int          err_count = 0;
    int          checks_done = 0;
    smd_supply_monitor #(.STARTUP_CYC(4), .FILTER_CYC(4),
        .LH_CYC_P('{40, 80, 160, 320, 640, 1280, 2560, 5120})) uut (
        .sys_clk, .rst, .regReq(req), .regRdData(rdData), .regRdValid(rdv),
        .anaIn(ana), .nvmCfg(nvm), .gateSupplyOn(gOn), .switchEn1(sw1),
        .switchEn2(sw2), .failSilent(fsil), .fallbackActive(fbAct));
    smd_host_model host (.sys_clk, .regRdData(rdData), .regReq(req));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check(input string n, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rdChk(input logic [6:0] a, input logic [7:0] m, exp);
        host.regRead(a, v);
        check("read valid", 8'(rdv), 8'h01);
        check($sformatf("reg %h", a), v & m, exp);
    endtask
    task automatic waitHigh(ref logic s);
        for (int i = 0; i < 200 && s !== 1'b1; i++) @(posedge sys_clk);
    endtask
    task automatic resetDut;
        @(posedge sys_clk) rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_count++;
        complete_run;
    end
    initial begin
        rst = 1'b1;
        ana = '0;
        nvm = '0;
        resetDut;
        rdChk(ADDR_FUNC_CTRL, 8'hff, 8'h00);
        rdChk(ADDR_GATE_CODE, 8'hff, 8'h80);
        rdChk(ADDR_OV_THR, 8'hff, 8'hff);
        rdChk(ADDR_UV_THR, 8'hff, 8'h00);
        host.regWrite(ADDR_GATE_CODE, 8'h5c);
        rdChk(ADDR_GATE_CODE, 8'hff, 8'h80);
        rdChk(ADDR_DIAG, 8'h1f, 8'h02);
        host.regWrite(ADDR_DIAG, 8'h00);
        rdChk(ADDR_DIAG, 8'h1f, 8'h00);
        host.regWrite(ADDR_GATE_CODE, 8'hb8);
        rdChk(ADDR_GATE_CODE, 8'hff, 8'h80);
        @(posedge sys_clk) nvm.rangeExt <= 1'b1;
        host.regWrite(ADDR_GATE_CODE, 8'h5d);
        rdChk(ADDR_GATE_CODE, 8'hff, 8'h5d);
        $display("test register access done");
        host.regWrite(ADDR_UV_THR, 8'h10);
        @(posedge sys_clk) ana <= '{vbatCode: 8'h20, gateInWindow: 1'b1,
            out1InWindow: 1'b1, default: '0};
        host.regWrite(ADDR_FUNC_CTRL, 8'h03);
        waitHigh(sw1);
        check("switch1", 8'(sw1), 8'h01);
        check("supply_on", 8'(gOn), 8'h01);
        check("switch2", 8'(sw2), 8'h00);
        host.regWrite(ADDR_GATE_CODE, 8'h90);
        rdChk(ADDR_GATE_CODE, 8'hff, 8'h5d);
        rdChk(ADDR_VBAT_READ, 8'hff, 8'h20);
        repeat (12) @(posedge sys_clk);
        rdChk(ADDR_DIAG, 8'ha0, 8'ha0);
        @(posedge sys_clk) ana.vbatCode <= 8'h05;
        waitHigh(fsil);
        check("switch1", 8'(sw1), 8'h00);
        check("supply_on", 8'(gOn), 8'h00);
        rdChk(ADDR_DIAG, 8'h0c, 8'h08);
        @(posedge sys_clk) ana.vbatCode <= 8'h20;
        // healthy code must clear the synchroniser, or the old fault re-sets the flag
        repeat (2) @(posedge sys_clk);
        host.regWrite(ADDR_DIAG, 8'hff);
        rdChk(ADDR_DIAG, 8'h1c, 8'h00);
        check("failsilent", 8'(fsil), 8'h01);
        @(posedge sys_clk) nvm.restartUv <= 1'b1;
        waitHigh(sw1);
        check("restart", 8'(sw1), 8'h01);
        $display("test supervision done");
        @(posedge sys_clk) nvm <= '{limpEnable: 1'b1, default: '0};
        resetDut;
        host.regWrite(ADDR_FUNC_CTRL, 8'h01);
        repeat (25) @(posedge sys_clk);
        host.regWrite(ADDR_LIMP_CTRL, 8'h70);
        repeat (25) @(posedge sys_clk);
        check("fallback", 8'(fbAct), 8'h00);
        waitHigh(fbAct);
        rdChk(ADDR_FALLBACK, 8'h08, 8'h08);
        rdChk(ADDR_GATE_CODE, 8'hff, 8'h00);
        for (int i = 0; i < 3; i++) host.regWrite(ADDR_LIMP_CTRL, 8'(8'h10 << i));
        @(posedge sys_clk);
        check("fallback", 8'(fbAct), 8'h00);
        @(posedge sys_clk) nvm.useMode <= 1'b1;
        host.regWrite(ADDR_FUNC_CTRL, 8'h03);
        repeat (10) @(posedge sys_clk);
        check("supply_on", 8'(gOn), 8'h00);
        $display("test fallback done");
        complete_run;
    end
endmodule
